// *** rtl/ext_irq_pin_config.sv ***
// external interrupt pin configuration, edge sensing and enables
`timescale 1ns/1ps

// Notes on behaviour
// - filter samples pin0 every 256 states
// - function bit 7 enables pin0 filter
// - function bit 6 selects event counter input
// - function bit 5 selects interrupt input 5
// - function bit 4 selects interrupt input 4
// - function bit 1 selects interrupt input 1
// - function bit 0 selects interrupt input 0
// - function bits 3,2 read one, unwritable
// - edge-select bits 7-5,3,2 read one
// - edge bit 4: 0 falling, 1 rising
// - edge bit 1: 0 falling, 1 rising
// - edge bit 0: 0 falling, 1 rising
// - enable bits 5,4 gate requests 5,4
// - enable bits 1,0 gate requests 1,0
// - enable bits 7,6 read one; 3,2 plain
// - second enable register fully read/write
// - input 5 always senses falling edge
// - flag sets only on selected edge of a pin selected as interrupt, whatever its enable bit
// - flag clears only by software writing zero
module ext_irq_pin_config
   import ext_irq_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   // avalon-mm slave
   input  wire logic [5:0]  i_address,
   input  wire logic        i_read,
   input  wire logic        i_write,
   input  wire logic [31:0] i_writedata,
   input  wire logic [3:0]  i_byteenable,
   output logic      [31:0] o_readdata,
   output logic             o_waitrequest,
   // port 1 pins (raw, asynchronous)
   input  wire logic [3:0]  i_ext_int_pins,
   // pin function selects
   output logic             o_pin0_as_interrupt,
   output logic             o_pin1_as_interrupt,
   output logic             o_pin4_as_interrupt,
   output logic             o_pin5_as_interrupt,
   output logic             o_event_input_sel,
   // requests to the priority logic
   output logic [3:0]       o_ext_irq_req,
   output logic [5:0]       o_tmr_dt_enable
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [7:0] pin_function, next_pin_function;
   logic [7:0] edge_select,  next_edge_select;
   logic [7:0] ext_enable,   next_ext_enable;
   logic [7:0] tmr_enable,   next_tmr_enable;
   logic [3:0] flags,        next_flags;
   logic [3:0] sync1, sync2;
   logic [3:0] level_prev,   next_level_prev;
   logic [7:0] div_cnt,      next_div_cnt;
   logic       sample_prev,  next_sample_prev;
   logic       filt_level,   next_filt_level;
   logic       ack,          next_ack;
   logic       waitreq,      next_waitreq;
   logic [31:0] rdata,       next_rdata;
   logic [3:0] req,          next_req;

   logic [3:0] level_now;
   logic [3:0] edge_hit;
   logic [3:0] pin_irq_sel;
   logic [3:0] edge_rise;
   logic       wr_acc;
   logic [3:0] idx;
   logic [3:0] en_sel;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] masked_write(input logic [7:0] old,
                                                input logic [7:0] wd,
                                                input logic [7:0] wm,
                                                input logic [7:0] fx);
      masked_write = (wd & wm) | (old & ~wm & ~fx) | fx;
   endfunction : masked_write

   // compact flag nibble -> register byte layout (bits 5,4,1,0)
   function automatic logic [7:0] flags_to_byte(input logic [3:0] f);
      flags_to_byte = {2'b11, f[3:2], 2'b00, f[1:0]};
   endfunction : flags_to_byte

   // ----------------------------------------------------------------
   // pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         sync1 <= 4'hf;
         sync2 <= 4'hf;
      end else begin
         sync1 <= i_ext_int_pins;
         sync2 <= sync1;
      end
   end

   // ----------------------------------------------------------------
   // noise filter on input 0
   // ----------------------------------------------------------------
   always_comb begin
      next_div_cnt     = div_cnt + 8'h01;
      next_sample_prev = sample_prev;
      next_filt_level  = filt_level;
      if (div_cnt == FILTER_LAST) begin
         next_div_cnt     = 8'h00;
         next_sample_prev = sync2[0];
         // two agreeing samples accept the level, else noise
         if (sync2[0] == sample_prev) begin
            next_filt_level = sync2[0];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         div_cnt     <= 8'h00;
         sample_prev <= 1'b1;
         filt_level  <= 1'b1;
      end else begin
         div_cnt     <= next_div_cnt;
         sample_prev <= next_sample_prev;
         filt_level  <= next_filt_level;
      end
   end

   // ----------------------------------------------------------------
   // edge detection
   // ----------------------------------------------------------------
   always_comb begin
      level_now    = sync2;
      if (pin_function[BIT_NOISE_CANCEL]) begin
         level_now[0] = filt_level;
      end
      pin_irq_sel  = {pin_function[5], pin_function[4],
                      pin_function[1], pin_function[0]};
      edge_rise    = {1'b0, edge_select[4],
                      edge_select[1], edge_select[0]};
      en_sel       = {ext_enable[5], ext_enable[4],
                      ext_enable[1], ext_enable[0]};
      next_level_prev = level_now;
   end

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_edge
         assign edge_hit[g] = pin_irq_sel[g] &&
            (edge_rise[g] ? (level_now[g] & ~level_prev[g])
                          : (~level_now[g] & level_prev[g]));
      end
   endgenerate

   // ----------------------------------------------------------------
   // avalon-mm slave: one wait cycle, answer on the second edge
   // ----------------------------------------------------------------
   assign idx    = i_address[5:2];
   assign wr_acc = i_write && ack && i_byteenable[0];

   always_comb begin
      next_pin_function = pin_function;
      next_edge_select  = edge_select;
      next_ext_enable   = ext_enable;
      next_tmr_enable   = tmr_enable;
      next_flags        = flags;
      next_ack          = (i_read || i_write) && !ack;
      next_waitreq      = !next_ack;
      next_rdata        = 32'h0000_0000;
      if (wr_acc) begin
         case (idx)
            IDX_PIN_FUNCTION:
               next_pin_function = masked_write(pin_function,
                  i_writedata[7:0], WMASK_PIN_FUNC, FIXED_PIN_FUNC);
            IDX_EDGE_SELECT:
               next_edge_select = masked_write(edge_select,
                  i_writedata[7:0], WMASK_EDGE_SEL, FIXED_EDGE_SEL);
            IDX_EXT_ENABLE:
               next_ext_enable = masked_write(ext_enable,
                  i_writedata[7:0], WMASK_EXT_EN, FIXED_EXT_EN);
            IDX_TMR_DT_ENABLE:
               next_tmr_enable = i_writedata[7:0];
            IDX_REQ_FLAGS:
               next_flags = flags & {i_writedata[5:4],
                                     i_writedata[1:0]};
            default: ;
         endcase
      end
      // a new edge wins over a simultaneous clear
      next_flags = next_flags | edge_hit;
      if (i_read && !ack) begin
         case (idx)
            IDX_PIN_FUNCTION:  next_rdata = {24'h0, pin_function};
            IDX_EDGE_SELECT:   next_rdata = {24'h0, edge_select};
            IDX_EXT_ENABLE:    next_rdata = {24'h0, ext_enable};
            IDX_TMR_DT_ENABLE: next_rdata = {24'h0, tmr_enable};
            IDX_REQ_FLAGS:     next_rdata = {24'h0, flags_to_byte(flags)};
            IDX_PIN_STATUS:    next_rdata = {27'h0, filt_level, sync2};
            default:           next_rdata = 32'h0000_0000;
         endcase
      end else if (ack) begin
         next_rdata = rdata;
      end
      // gated requests; global masking lives outside
      next_req = flags & en_sel;
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         pin_function <= RST_PIN_FUNCTION;
         edge_select  <= RST_EDGE_SELECT;
         ext_enable   <= RST_EXT_ENABLE;
         tmr_enable   <= RST_TMR_DT_ENABLE;
         flags        <= 4'h0;
         level_prev   <= 4'hf;
         ack          <= 1'b0;
         waitreq      <= 1'b1;
         rdata        <= 32'h0000_0000;
         req          <= 4'h0;
      end else begin
         pin_function <= next_pin_function;
         edge_select  <= next_edge_select;
         ext_enable   <= next_ext_enable;
         tmr_enable   <= next_tmr_enable;
         flags        <= next_flags;
         level_prev   <= next_level_prev;
         ack          <= next_ack;
         waitreq      <= next_waitreq;
         rdata        <= next_rdata;
         req          <= next_req;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_readdata          = rdata;
   // own flop, so the bus never sees a gate on this path
   assign o_waitrequest       = waitreq;
   assign o_pin0_as_interrupt = pin_function[0];
   assign o_pin1_as_interrupt = pin_function[1];
   assign o_pin4_as_interrupt = pin_function[4];
   assign o_pin5_as_interrupt = pin_function[5];
   assign o_event_input_sel   = pin_function[BIT_EVENT_SEL];
   assign o_ext_irq_req       = req;
   assign o_tmr_dt_enable     = tmr_enable[5:0];

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   sequence s_write_to(logic [3:0] r);
      i_write && ack && i_byteenable[0] && idx == r;
   endsequence

   // ----------------------------------------------------------------
   // per-input edge sequences
   // ----------------------------------------------------------------
   sequence s_armed_rise(int k);
      pin_irq_sel[k] && edge_rise[k] && !level_prev[k] && level_now[k];
   endsequence

   sequence s_armed_fall(int k);
      pin_irq_sel[k] && !edge_rise[k] && level_prev[k] && !level_now[k];
   endsequence

   // the opposite edge must leave a clear flag clear
   sequence s_wrong_edge(int k);
      pin_irq_sel[k] && !flags[k] && (edge_rise[k] ?
         (level_prev[k] && !level_now[k]) :
         (!level_prev[k] && level_now[k]));
   endsequence

   a_pin_fixed_bits: assert property (
      pin_function[3:2] == 2'b11)
      else $error("pin function reserved bits not one");
   a_edge_fixed_bits: assert property (
      edge_select[7:5] == 3'b111 && edge_select[3:2] == 2'b11)
      else $error("edge select reserved bits not one");
   a_enable_fixed: assert property (
      ext_enable[7:6] == 2'b11)
      else $error("enable reserved bits not one");
   a_flag_needs_sel: assert property (
      $rose(flags[3]) |-> $past(pin_function[5]))
      else $error("flag 5 set while pin not interrupt");
   a_in5_falling: assert property (
      $rose(flags[3]) |-> $past(level_prev[3]) && !$past(level_now[3]))
      else $error("input 5 flag without falling edge");
   a_flag_holds: assert property (
      $fell(flags[0]) |-> $past(wr_acc) && $past(idx) == IDX_REQ_FLAGS)
      else $error("flag cleared without software write");
   a_req_gated: assert property (
      o_ext_irq_req[0] |-> $past(flags[0]) && $past(ext_enable[0]))
      else $error("request 0 passed while disabled");
   a_req_follow: assert property (
      flags[2] && ext_enable[4] |=> o_ext_irq_req[2])
      else $error("enabled request 4 not presented");
   a_filter_period: assert property (
      filt_level != $past(filt_level) |-> $past(div_cnt) == FILTER_LAST)
      else $error("filter level moved off sample point");
   a_tmr_write: assert property (
      s_write_to(IDX_TMR_DT_ENABLE) |=> tmr_enable ==
         $past(i_writedata[7:0]))
      else $error("timer enable write lost");
   a_func_write: assert property (
      s_write_to(IDX_PIN_FUNCTION) |=> pin_function ==
         (($past(i_writedata[7:0]) & WMASK_PIN_FUNC) | FIXED_PIN_FUNC))
      else $error("pin function write not applied");
   a_sel_outputs: assert property (
      s_write_to(IDX_PIN_FUNCTION) |=>
         {o_event_input_sel, o_pin5_as_interrupt, o_pin4_as_interrupt,
          o_pin1_as_interrupt, o_pin0_as_interrupt} ==
         {$past(i_writedata[6]), $past(i_writedata[5]),
          $past(i_writedata[4]), $past(i_writedata[1]),
          $past(i_writedata[0])})
      else $error("pin function selects not driven");
   a_edge_write: assert property (
      s_write_to(IDX_EDGE_SELECT) |=> edge_select ==
         (($past(i_writedata[7:0]) & WMASK_EDGE_SEL) | FIXED_EDGE_SEL))
      else $error("edge select write not applied");
   a_enable_write: assert property (
      s_write_to(IDX_EXT_ENABLE) |=> ext_enable ==
         (($past(i_writedata[7:0]) & WMASK_EXT_EN) | FIXED_EXT_EN))
      else $error("interrupt enable write not applied");
   a_filter_agree: assert property (
      filt_level != $past(filt_level) |->
         $past(sync2[0]) == $past(sample_prev))
      else $error("filter accepted disagreeing samples");
   a_filter_feeds: assert property (
      pin_function[BIT_NOISE_CANCEL] &&
      $past(pin_function[BIT_NOISE_CANCEL]) && $stable(filt_level)
      |-> !edge_hit[0])
      else $error("input 0 edge without filtered level change");

   // ----------------------------------------------------------------
   // per-input flag and request checks
   // ----------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < 4; c++) begin : g_chk
         // input 5 senses falling only, so no rising check there
         if (c != 3) begin : g_rise
            a_rise_sets: assert property (
               s_armed_rise(c) |=> flags[c])
               else $error("selected rising edge did not set flag");
         end
         a_fall_sets: assert property (
            s_armed_fall(c) |=> flags[c])
            else $error("selected falling edge did not set flag");
         a_wrong_edge: assert property (
            s_wrong_edge(c) |=> !flags[c])
            else $error("unselected edge set a flag");
         a_port_quiet: assert property (
            !pin_irq_sel[c] && !flags[c] |=> !flags[c])
            else $error("flag set while pin in port mode");
         a_flag_sticky: assert property (
            flags[c] && !(wr_acc && idx == IDX_REQ_FLAGS) |=> flags[c])
            else $error("flag cleared without software write");
         a_req_match: assert property (
            o_ext_irq_req[c] == $past(flags[c] && en_sel[c]))
            else $error("request differs from enabled flag");
      end
   endgenerate

endmodule : ext_irq_pin_config

// *** inc/ext_irq_pkg.sv ***
// constants for the external interrupt pin configuration block
package ext_irq_pkg;
   // ----------------------------------------------------------------
   // register indices (byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam logic [3:0] IDX_PIN_FUNCTION  = 4'h0;
   localparam logic [3:0] IDX_EDGE_SELECT   = 4'h1;
   localparam logic [3:0] IDX_EXT_ENABLE    = 4'h2;
   localparam logic [3:0] IDX_TMR_DT_ENABLE = 4'h3;
   localparam logic [3:0] IDX_REQ_FLAGS     = 4'h4;
   localparam logic [3:0] IDX_PIN_STATUS    = 4'h5;
   // ----------------------------------------------------------------
   // reset values and fixed bits
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_PIN_FUNCTION  = 8'h0c;
   localparam logic [7:0] RST_EDGE_SELECT   = 8'hec;
   localparam logic [7:0] RST_EXT_ENABLE    = 8'hc0;
   localparam logic [7:0] RST_TMR_DT_ENABLE = 8'h00;
   localparam logic [7:0] RST_REQ_FLAGS     = 8'hc0;
   localparam logic [7:0] WMASK_PIN_FUNC    = 8'hf3;
   localparam logic [7:0] FIXED_PIN_FUNC    = 8'h0c;
   localparam logic [7:0] WMASK_EDGE_SEL    = 8'h13;
   localparam logic [7:0] FIXED_EDGE_SEL    = 8'hec;
   localparam logic [7:0] WMASK_EXT_EN      = 8'h3f;
   localparam logic [7:0] FIXED_EXT_EN      = 8'hc0;
   localparam logic [7:0] FLAG_MASK         = 8'h33;
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_NOISE_CANCEL = 7;
   localparam int BIT_EVENT_SEL    = 6;
   localparam int BIT_DT_ENABLE    = 5;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int          FILTER_STATES = 256;
   localparam logic [7:0]  FILTER_LAST   = 8'(FILTER_STATES - 1);
endpackage : ext_irq_pkg

// *** verif/ext_irq_pin_source.sv ***
// external signal source driving the port 1 interrupt pins
`timescale 1ns/1ps
module ext_irq_pin_source (
   // clock
   input  wire logic       i_clk,
   // pins {in5,in4,in1,in0}
   output logic      [3:0] o_pins
);
   // pins idle high, so reset sees no false edge
   initial o_pins = 4'hf;
   // ----------------------------------------------------------------
   // pin drivers, changed only just after a rising edge
   // ----------------------------------------------------------------
   task automatic drive(input int k, input logic v);
      @(posedge i_clk);
      o_pins[k] <= v;
   endtask : drive
   // short excursion, shorter than one filter interval
   task automatic glitch(input int k, input logic v, input int n);
      drive(k, v);
      repeat (n) @(posedge i_clk);
      o_pins[k] <= ~v;
   endtask : glitch
endmodule : ext_irq_pin_source

// *** verif/ext_irq_pin_config_test.sv ***
// self-checking bench for the external interrupt pin configuration
`timescale 1ns/1ps
module ext_irq_pin_config_test
   import ext_irq_pkg::*;
;
   logic        i_clk         = 1'b0;
   logic        i_nrst        = 1'b0;
   logic [5:0]  i_address     = 6'h00;
   logic        i_read        = 1'b0;
   logic        i_write       = 1'b0;
   logic [31:0] i_writedata   = 32'h0;
   logic [31:0] o_readdata;
   logic        o_waitrequest;
   logic [3:0]  pins;
   logic        p0, p1, p4, p5, ev;
   logic [3:0]  o_ext_irq_req;
   logic [5:0]  o_tmr_dt_enable;
   logic        ee;
   int          mismatches    = 0;
   int          total_checks  = 0;
   logic [7:0]  rst_v [4]     = '{8'h0c, 8'hec, 8'hc0, 8'h00};
   logic [7:0]  fbit [4]      = '{8'h01, 8'h02, 8'h10, 8'h20};

   always #2 i_clk = ~i_clk;

   ext_irq_pin_config u_dut (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_address(i_address),
      .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
      .i_byteenable(4'hf), .o_readdata(o_readdata),
      .o_waitrequest(o_waitrequest), .i_ext_int_pins(pins),
      .o_pin0_as_interrupt(p0), .o_pin1_as_interrupt(p1),
      .o_pin4_as_interrupt(p4), .o_pin5_as_interrupt(p5),
      .o_event_input_sel(ev), .o_ext_irq_req(o_ext_irq_req),
      .o_tmr_dt_enable(o_tmr_dt_enable));

   ext_irq_pin_source u_src (.i_clk(i_clk), .o_pins(pins));

   // ----------------------------------------------------------------
   // bus access and comparison
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [7:0] exp, got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : check

   // request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic wr, input logic [3:0] idx,
                      input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      @(posedge i_clk);
      i_address   <= {idx, 2'b00};
      i_writedata <= {24'h0, wd};
      i_write     <= wr;
      i_read      <= ~wr;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_waitrequest !== 1'b0 && n < 50);
      rd = o_readdata[7:0];
      i_write <= 1'b0;
      i_read  <= 1'b0;
      if (n >= 50) mismatches++;
   endtask : bus

   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      logic [7:0] x;
      bus(1'b1, idx, d, x);
   endtask : wr

   task automatic rdchk(input string nm, input logic [3:0] idx,
                        input logic [7:0] exp);
      logic [7:0] x;
      bus(1'b0, idx, 8'h00, x);
      check(nm, exp, x);
   endtask : rdchk

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge i_clk);
      i_nrst <= 1'b1;
      for (int r = 0; r < 4; r++) begin
         rdchk("reset_value", 4'(r), rst_v[r]);
         wr(4'(r), 8'hff);
         rdchk("write_ones", 4'(r), 8'hff);
         wr(4'(r), 8'h00);
         rdchk("write_zeros", 4'(r), rst_v[r]);
      end
      wr(4'hf, 8'hff);
      rdchk("unmapped", 4'hf, 8'h00);
      wr(IDX_PIN_FUNCTION, 8'h52);
      @(posedge i_clk);
      check("selects_a", 8'h16, {3'h0, ev, p5, p4, p1, p0});
      wr(IDX_PIN_FUNCTION, 8'ha1);
      @(posedge i_clk);
      check("selects_b", 8'h09, {3'h0, ev, p5, p4, p1, p0});
      wr(IDX_TMR_DT_ENABLE, 8'h2a);
      @(posedge i_clk);
      check("tmr_dt_en", 8'h2a, {2'h0, o_tmr_dt_enable});
      wr(IDX_TMR_DT_ENABLE, 8'h15);
      @(posedge i_clk);
      check("tmr_dt_en", 8'h15, {2'h0, o_tmr_dt_enable});
      $display("test registers done");
      for (int k = 0; k < 4; k++) begin
         for (int e = 0; e < 2; e++) begin
            ee = (k == 3) ? 1'b0 : 1'(e);
            wr(IDX_EXT_ENABLE, 8'h00);
            wr(IDX_PIN_FUNCTION, 8'h33);
            wr(IDX_EDGE_SELECT, (e == 1) ? 8'hff : 8'h00);
            u_src.drive(k, ee);
            repeat (5) @(posedge i_clk);
            wr(IDX_REQ_FLAGS, 8'h00);
            u_src.drive(k, ~ee);
            repeat (5) @(posedge i_clk);
            rdchk("wrong_edge", IDX_REQ_FLAGS, 8'hc0);
            u_src.drive(k, ee);
            repeat (5) @(posedge i_clk);
            rdchk("right_edge", IDX_REQ_FLAGS, 8'hc0 | fbit[k]);
            check("gated_req", 8'h00, {4'h0, o_ext_irq_req});
            wr(IDX_EXT_ENABLE, 8'h33);
            repeat (2) @(posedge i_clk);
            check("passed_req", 8'(1 << k), {4'h0, o_ext_irq_req});
            wr(IDX_REQ_FLAGS, 8'hff);
            rdchk("no_autoclr", IDX_REQ_FLAGS, 8'hc0 | fbit[k]);
            wr(IDX_REQ_FLAGS, 8'h00);
            repeat (2) @(posedge i_clk);
            check("cleared_req", 8'h00, {4'h0, o_ext_irq_req});
         end
      end
      wr(IDX_EXT_ENABLE, 8'h00);
      wr(IDX_PIN_FUNCTION, 8'h00);
      wr(IDX_REQ_FLAGS, 8'h00);
      for (int k = 0; k < 4; k++) begin
         u_src.drive(k, 1'b1);
         u_src.drive(k, 1'b0);
      end
      repeat (5) @(posedge i_clk);
      rdchk("port_mode", IDX_REQ_FLAGS, 8'hc0);
      $display("test edges done");
      // filter intervals are long, so settle well past two of them
      wr(IDX_EDGE_SELECT, 8'h00);
      wr(IDX_PIN_FUNCTION, 8'h81);
      u_src.drive(0, 1'b1);
      repeat (700) @(posedge i_clk);
      wr(IDX_REQ_FLAGS, 8'h00);
      u_src.glitch(0, 1'b0, 20);
      repeat (700) @(posedge i_clk);
      rdchk("glitch", IDX_REQ_FLAGS, 8'hc0);
      u_src.drive(0, 1'b0);
      repeat (200) @(posedge i_clk);
      rdchk("early", IDX_REQ_FLAGS, 8'hc0);
      repeat (600) @(posedge i_clk);
      rdchk("stable", IDX_REQ_FLAGS, 8'hc1);
      $display("test filter done");
      end_of_test();
   end

   initial begin
      repeat (40000) @(posedge i_clk);
      mismatches++;
      end_of_test();
   end
endmodule : ext_irq_pin_config_test
